// >>> bench/isx_regfile_model.sv
module isx_regfile_model
  import isx_pkg::*;
(
  // Clock
  input  wire logic       mclk,
  // Register file access
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  output logic [7:0]      reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];

  // Seeded near ff so increments wrap often
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(255 - i);
  end

  assign reg_rdata = mem[reg_addr];

  always @(posedge mclk)
  begin
    if (reg_we)
      mem[reg_addr] <= reg_wdata;
  end
endmodule

// >>> bench/test_incskip_orlit_nop_exec.sv
module test_incskip_orlit_nop_exec
  import isx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rstn, clk_en, opcode_valid, reg_we, zero_flag;
  logic        cycle_done, skipping;
  logic [13:0] opcode;
  logic [7:0]  reg_rdata, reg_wdata, work, r1, r2;
  logic [6:0]  reg_addr;
  logic [1:0]  phase;
  int          n_fail, tests_run, cyc, m[128], w, z, skp;

  isx_exec u_isx_exec (.mclk(mclk), .rstn(rstn), .clk_en(clk_en),
    .opcode(opcode), .opcode_valid(opcode_valid), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .work(work), .zero_flag(zero_flag), .phase(phase),
    .cycle_done(cycle_done), .skipping(skipping));
  isx_regfile_model u_isx_regfile_model (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata));

  function automatic logic [7:0] lf(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Drive one instruction, optionally held one clock by clk_en, then
  // check every output, reg_wdata only on a write, once its four phases have run; the write pulse
  // stands one cycle unless clk_en is held low, so it is looked at right after the Q4 edge
  task automatic step(logic [13:0] op, logic v, logic stall);
    int r, ewe, ewd, esk;
    opcode = op;
    opcode_valid = v;
    ewe = 0;
    ewd = 0;
    esk = skp;
    if (stall)
    begin
      clk_en = 1'b0;
      @(negedge mclk);
      chk(8'(phase), 8'(PHASE_RESET));
      chk(work, 8'(w));
      clk_en = 1'b1;
    end
    if (skp != 0)
      skp = 0;
    else if (v && op[13:8] == INC_SKIP_TOP)
    begin
      r = (m[op[6:0]] + 1) % 256;
      if (op[7])
      begin
        m[op[6:0]] = r;
        ewe = 1;
        ewd = r;
      end
      else
        w = r;
      skp = (r == 0);
    end
    else if (v && op[13:8] == OR_LIT_TOP)
    begin
      w = w | op[7:0];
      z = (w == 0);
    end
    @(negedge mclk);
    chk(8'(phase), 8'h01);
    chk(8'(reg_we), 8'h00);
    repeat (3) @(negedge mclk);
    chk(work, 8'(w));
    chk(8'(zero_flag), 8'(z));
    chk(8'(reg_we), 8'(ewe));
    if (ewe != 0)
      chk(reg_wdata, 8'(ewd));
    chk(8'(skipping), 8'(esk));
    chk(8'(cycle_done), 8'h01);
    chk(8'(phase), 8'(PHASE_RESET));
    chk(8'(reg_addr), v ? 8'(op[6:0]) : 8'h00);
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  initial
  begin
    rstn = 1'b0;
    clk_en = 1'b1;
    opcode = 14'h0000;
    opcode_valid = 1'b0;
    r1 = 8'h4e;
    for (int i = 0; i < 128; i++)
      m[i] = 255 - i;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    step(14'h3800, 1'b1, 1'b0);
    step(14'h3835, 1'b1, 1'b0);
    step(14'h0f80, 1'b1, 1'b0);
    step(14'h3e0f, 1'b1, 1'b0);
    step(14'h0f00, 1'b1, 1'b1);
    step(14'h38ff, 1'b1, 1'b0);
    step(14'h3800, 1'b1, 1'b0);
    step(14'h0060, 1'b1, 1'b0);
    $display("test directed done");
    // Reset in mid-run; the last step wrote nothing, so no write is lost
    rstn = 1'b0;
    @(negedge mclk);
    chk(work, W_RESET);
    chk(8'(zero_flag), 8'h00);
    chk(8'(reg_we), 8'h00);
    chk(8'(phase), 8'(PHASE_RESET));
    chk(8'(cycle_done | skipping), 8'h00);
    rstn = 1'b1;
    w = W_RESET;
    z = 0;
    skp = 0;
    step(14'h3800, 1'b1, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 300; i++)
    begin
      r1 = lf(r1);
      r2 = lf(lf(r1));
      case (r1[1:0])
        2'h0: step({6'h0f, r1[2], 4'h0, r2[2:0]}, r1[4] | r1[3], r1[5]);
        2'h1: step({6'h38, r2 & {8{r1[6]}}}, r1[4] | r1[3], r1[5]);
        2'h2: step({7'h00, r2[1:0], 5'h00}, 1'b1, r1[5]);
        default: step({6'h20, r2}, r1[4] | r1[3], r1[5]);
      endcase
    end
    step(14'h0000, 1'b1, 1'b0);
    $display("test random done");
    give_verdict();
  end
endmodule

// >>> rtl/isx_decode.sv
module isx_decode
  import isx_pkg::*;
(
  // Opcode in
  input  wire logic [13:0] opcode,
  // Decoded class and fields
  output isx_op_t          op,
  output logic             dest_reg,
  output logic [6:0]       reg_addr,
  output logic [7:0]       literal
);
  always_comb
  begin
    op = ISX_OP_OTHER;
    if (opcode[TOP6_MSB:TOP6_LSB] == INC_SKIP_TOP)
      op = ISX_OP_INC_SKIP;
    else if (opcode[TOP6_MSB:TOP6_LSB] == OR_LIT_TOP)
      op = ISX_OP_OR_LIT;
    else if ((opcode & NOP_MASK) == NOP_MATCH)
      op = ISX_OP_NOP;
  end

  assign dest_reg = opcode[DEST_BIT];
  assign reg_addr = opcode[ADDR_W-1:0];
  assign literal  = opcode[DATA_W-1:0];
endmodule

// >>> rtl/isx_exec.sv
// Functional notes
// - Opcode 00 1111 d fffffff decodes as increment-skip-if-zero.
// - Destination bit 0: incremented value goes to working register.
// - Destination bit 1: incremented value written back to data register.
// - Zero result discards next instruction, runs a no-op cycle instead.
// - Nonzero result: one cycle, next executes, status flags untouched.
// - Opcode 11 1000 kkkkkkkk decodes as or-literal, one cycle.
// - Opcode 00 0000 0xx0 0000 is a no-op changing no state.
module isx_exec
  import isx_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  // Fetch path
  input  wire logic [13:0] opcode,
  input  wire logic        opcode_valid,
  // Data register file read
  input  wire logic [7:0]  reg_rdata,
  // Data register file write and read address
  output logic [6:0]       reg_addr,
  output logic [7:0]       reg_wdata,
  output logic             reg_we,
  // Working register and status
  output logic [7:0]       work,
  output logic             zero_flag,
  // Cycle status
  output logic [1:0]       phase,
  output logic             cycle_done,
  output logic             skipping
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  isx_op_t    op;
  logic       dest_reg;
  logic [6:0] dec_addr;
  logic [7:0] literal;
  isx_state_t state;
  logic [13:0] ir;
  logic [7:0]  result;
  logic        last_q;

  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = v + 8'h01;
  endfunction

  isx_decode u_dec
  (
    .opcode   (ir),
    .op       (op),
    .dest_reg (dest_reg),
    .reg_addr (dec_addr),
    .literal  (literal)
  );

  assign last_q = (phase == PHASE_LAST);

  // ****************************************************************
  // Four-phase cycle counter
  // ****************************************************************
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      phase <= PHASE_RESET;
    else if (clk_en)
      phase <= phase + 2'h1;
  end

  // Opcode latched in Q1 so the rest of the cycle sees a stable word
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ir <= NOP_MATCH;
    else if (clk_en && phase == PHASE_RESET)
      ir <= opcode_valid ? opcode : NOP_MATCH;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      reg_addr <= 7'h00;
    else if (clk_en)
      reg_addr <= dec_addr;
  end

  assign result = inc8(reg_rdata);

  // ****************************************************************
  // Skip state machine
  // ****************************************************************
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state <= ISX_ST_EXEC;
    else if (clk_en && last_q)
    begin
      case (state)
        ISX_ST_EXEC:
          if (op == ISX_OP_INC_SKIP && result == 8'h00)
            state <= ISX_ST_SKIP;
        ISX_ST_SKIP:
          state <= ISX_ST_EXEC;
        default:
          state <= ISX_ST_EXEC;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      skipping <= 1'b0;
    else if (clk_en)
      skipping <= (state == ISX_ST_SKIP);
  end

  // ****************************************************************
  // Write to destination in Q4
  // ****************************************************************
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      work <= W_RESET;
    else if (clk_en && last_q && state == ISX_ST_EXEC)
    begin
      if (op == ISX_OP_INC_SKIP && !dest_reg)
        work <= result;
      else if (op == ISX_OP_OR_LIT)
        work <= work | literal;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      zero_flag <= 1'b0;
    else if (clk_en && last_q && state == ISX_ST_EXEC
             && op == ISX_OP_OR_LIT)
      zero_flag <= ((work | literal) == 8'h00);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_we    <= 1'b0;
      reg_wdata <= 8'h00;
    end
    else if (clk_en)
    begin
      reg_we    <= last_q && state == ISX_ST_EXEC
                   && op == ISX_OP_INC_SKIP && dest_reg;
      reg_wdata <= result;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      cycle_done <= 1'b0;
    else if (clk_en)
      cycle_done <= last_q;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  inc_to_work_a: assert property (
    clk_en && last_q && state == ISX_ST_EXEC && op == ISX_OP_INC_SKIP
    && !dest_reg |=> work == $past(result))
    else $error("increment not placed in working register");

  inc_to_reg_a: assert property (
    clk_en && last_q && state == ISX_ST_EXEC && op == ISX_OP_INC_SKIP
    && dest_reg |=> reg_we && reg_wdata == $past(result))
    else $error("increment not written back");

  zero_skip_a: assert property (
    clk_en && last_q && state == ISX_ST_EXEC && op == ISX_OP_INC_SKIP
    && result == 8'h00 |=> state == ISX_ST_SKIP)
    else $error("zero result did not skip");

  nonzero_flags_a: assert property (
    clk_en && last_q && state == ISX_ST_EXEC && op == ISX_OP_INC_SKIP
    && result != 8'h00 |=> state == ISX_ST_EXEC && $stable(zero_flag))
    else $error("nonzero increment skipped or touched flags");

  or_lit_a: assert property (
    clk_en && last_q && state == ISX_ST_EXEC && op == ISX_OP_OR_LIT
    |=> work == ($past(work) | $past(literal)))
    else $error("or-literal result wrong");

  zero_flag_a: assert property (
    clk_en && last_q && state == ISX_ST_EXEC && op == ISX_OP_OR_LIT
    |=> zero_flag == (work == 8'h00))
    else $error("zero flag wrong");

  nop_still_a: assert property (
    clk_en && last_q && op == ISX_OP_NOP
    |=> $stable(work) && $stable(zero_flag) && !reg_we)
    else $error("no-op changed state");

  skip_quiet_a: assert property (
    clk_en && last_q && state == ISX_ST_SKIP
    |=> $stable(work) && !reg_we && state == ISX_ST_EXEC)
    else $error("skipped cycle had effect");

  decode_inc_a: assert property (
    ir[13:8] == INC_SKIP_TOP |-> op == ISX_OP_INC_SKIP)
    else $error("increment-skip not decoded");

  decode_or_a: assert property (
    ir[13:8] == OR_LIT_TOP |-> op == ISX_OP_OR_LIT)
    else $error("or-literal not decoded");

  skip_c: cover property (state == ISX_ST_SKIP);
  or_zero_c: cover property (clk_en && last_q && op == ISX_OP_OR_LIT
                             && literal == 8'h00 && work == 8'h00);
  wb_c: cover property (reg_we);
endmodule

// >>> rtl/isx_pkg.sv
package isx_pkg;
  // ****************************************************************
  // Opcode layout
  // ****************************************************************
  localparam int          OPC_W        = 14;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 7;
  localparam int          DEST_BIT     = 7;
  localparam int          TOP6_MSB     = 13;
  localparam int          TOP6_LSB     = 8;
  localparam logic [5:0]  INC_SKIP_TOP = 6'h0f;
  localparam logic [5:0]  OR_LIT_TOP   = 6'h38;
  localparam logic [13:0] NOP_MASK     = 14'h3f9f;
  localparam logic [13:0] NOP_MATCH    = 14'h0000;
  // ****************************************************************
  // Reset values and last phase
  // ****************************************************************
  localparam logic [7:0]  W_RESET      = 8'h00;
  localparam logic [1:0]  PHASE_RESET  = 2'h0;
  localparam logic [1:0]  PHASE_LAST   = 2'h3;

  typedef enum logic [1:0] {
    ISX_OP_NOP,
    ISX_OP_INC_SKIP,
    ISX_OP_OR_LIT,
    ISX_OP_OTHER
  } isx_op_t;

  typedef enum {
    ISX_ST_EXEC,
    ISX_ST_SKIP
  } isx_state_t;
endpackage
